// ### verilog/dldc_top.v
// Dual line driver control: two 24V driver controls, receiver, wake and undervoltage logic
//
// Functional notes
// R1: Out2 driver enabled while out2_driver_off low
// R2: Line drives inverse of dio_logic_in
// R3: Line transmitter enabled only while enable high
// R4: Receive output is inverse of line
// R5: Mask set holds receive output high
// R6: Wake pulse low for 50us
// R7: Out2 drives inverse of out2_drive_in
// R8: Line level from pin or set bit
// R9: Line level on pin and status bit
// R10: Out2 controllable through line config bits
// R11: Line push-pull when select is one
// R12: Open-drain line picks low or high side
// R13: Push-pull line drives both levels
// R14: Out2 push-pull when select is one
// R15: Open-drain out2 picks low or high side
// R16: Undervoltage releases open-drain flag output
// R17: Line short held 410us means wake
// R18: Mask cleared resumes normal receive output
// R19: Mode writes apply immediately to drivers; outputs change one cycle after the config register
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "dldc_consts.vh"

module dldc_top #(
  parameter WAKE_DET_CYC = `DLDC_WAKE_DET_CYC,
  parameter WAKE_LOW_CYC = `DLDC_WAKE_LOW_CYC
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // Register port
  input wire [`DLDC_ADDR_W-1:0] reg_addr,
  input wire [`DLDC_DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`DLDC_DATA_W-1:0] reg_rdata,
  // Logic side pins
  input wire dio_logic_in,
  input wire line_driver_enable,
  input wire out2_drive_in,
  input wire out2_driver_off,
  input wire undervolt_detect,
  output reg line_receive_out,
  output wire wake_pulse_n,
  // Bidirectional line
  input wire bidir_line_in,
  output reg bidir_line_out,
  output reg bidir_line_oe_n,
  // Output-only line
  output reg output_line2_out,
  output reg output_line2_oe_n,
  // Undervoltage open-drain flag
  output wire undervoltage_flag_out,
  output reg undervoltage_flag_oe_n
);

  reg [`DLDC_DATA_W-1:0] line_cfg_r;
  reg [`DLDC_DATA_W-1:0] out2_cfg_r;
  reg line_sense_r;
  reg line_short_r;
  wire wake_active;
  wire line_level;
  wire out2_level;
  wire line_drive;
  wire out2_drive;

  // Decide whether a driver actively drives for a mode and level
  function drive_active;
    input push_pull;
    input sink_mode;
    input level;
    begin
      if (push_pull) begin
        drive_active = 1'b1;
      end else if (sink_mode) begin
        drive_active = ~level;
      end else begin
        drive_active = level;
      end
    end
  endfunction

  // Level sources
  assign line_level = line_cfg_r[`DLDC_LC_LEVEL_SRC] ? line_cfg_r[`DLDC_LC_LEVEL_SET] :
                      ~dio_logic_in; // R2 R8
  assign out2_level = line_cfg_r[`DLDC_LC_OUT2_SRC] ? line_cfg_r[`DLDC_LC_OUT2_SET] :
                      ~out2_drive_in; // R7 R10

  // Mode resolution uses live config so writes take effect next cycle
  assign line_drive = line_driver_enable && // R3
                      drive_active(line_cfg_r[`DLDC_LC_PUSH_PULL], // R11 R13 R19
                                   line_cfg_r[`DLDC_LC_SINK_SOURCE], line_level); // R12
  assign out2_drive = !out2_driver_off && // R1
                      drive_active(out2_cfg_r[`DLDC_OC_PUSH_PULL], // R14 R19
                                   out2_cfg_r[`DLDC_OC_SINK_SOURCE], out2_level); // R15

  // Undervoltage flag pulls low only while supplies are good
  assign undervoltage_flag_out = 1'b0;

  // Register writes
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      line_cfg_r <= `DLDC_LINE_CFG_RST;
      out2_cfg_r <= `DLDC_OUT2_CFG_RST;
    end else if (reg_wr) begin
      if (reg_addr == `DLDC_LINE_CFG_ADDR) begin
        line_cfg_r <= reg_wdata & `DLDC_LC_USED_MASK; // R19
      end
      if (reg_addr == `DLDC_OUT2_CFG_ADDR) begin
        out2_cfg_r <= reg_wdata & `DLDC_OC_USED_MASK; // R19
      end
    end
  end

  // Register reads, data valid in the following cycle only
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `DLDC_LINE_CFG_ADDR: reg_rdata <= line_cfg_r;
        `DLDC_OUT2_CFG_ADDR: reg_rdata <= out2_cfg_r;
        `DLDC_STATUS_ADDR: reg_rdata <= {4'h0, line_short_r, wake_active,
                                         undervolt_detect, line_sense_r}; // R9
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Pin outputs and line sensing
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      line_sense_r <= 1'b0;
      line_short_r <= 1'b0;
      line_receive_out <= 1'b1;
      bidir_line_out <= 1'b0;
      bidir_line_oe_n <= 1'b1;
      output_line2_out <= 1'b0;
      output_line2_oe_n <= 1'b1;
      undervoltage_flag_oe_n <= 1'b1;
    end else begin
      line_sense_r <= bidir_line_in; // R9
      // Short: line sensed against the level being actively driven
      line_short_r <= !bidir_line_oe_n && (bidir_line_in != bidir_line_out);
      line_receive_out <= line_cfg_r[`DLDC_LC_RX_MASK] ? 1'b1 : // R5
                          ~bidir_line_in; // R4 R18
      bidir_line_out <= line_level; // R2 R13
      bidir_line_oe_n <= ~line_drive; // R3 R11 R12
      output_line2_out <= out2_level; // R7
      output_line2_oe_n <= ~out2_drive; // R1 R14 R15
      undervoltage_flag_oe_n <= undervolt_detect; // R16
    end
  end

  dldc_wake_det #(
    .DET_CYC(WAKE_DET_CYC),
    .LOW_CYC(WAKE_LOW_CYC)
  ) u_wake (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .line_short(line_short_r), // R17
    .wake_pulse_n(wake_pulse_n), // R6
    .wake_active(wake_active)
  );

endmodule
`default_nettype wire

// ### common/dldc_consts.vh
// Register map, field positions, reset values and timing for the dual line driver control
`ifndef DLDC_CONSTS_VH
`define DLDC_CONSTS_VH

`define DLDC_ADDR_W 8
`define DLDC_DATA_W 8

`define DLDC_LINE_CFG_ADDR 8'h00
`define DLDC_OUT2_CFG_ADDR 8'h04
`define DLDC_STATUS_ADDR 8'h08

`define DLDC_LINE_CFG_RST 8'h01
`define DLDC_OUT2_CFG_RST 8'h01

// line_config_reg fields
`define DLDC_LC_PUSH_PULL 0
`define DLDC_LC_SINK_SOURCE 1
`define DLDC_LC_RX_MASK 2
`define DLDC_LC_LEVEL_SET 3
`define DLDC_LC_LEVEL_SRC 4
`define DLDC_LC_OUT2_SET 5
`define DLDC_LC_OUT2_SRC 6
`define DLDC_LC_USED_MASK 8'h7f

// out2_config_reg fields
`define DLDC_OC_PUSH_PULL 0
`define DLDC_OC_SINK_SOURCE 1
`define DLDC_OC_USED_MASK 8'h03

// Status fields
`define DLDC_ST_LINE_LEVEL 0
`define DLDC_ST_UNDERVOLT 1
`define DLDC_ST_WAKE_ACTIVE 2
`define DLDC_ST_LINE_SHORT 3

// Timing
`define DLDC_CLK_MHZ 20
`define DLDC_WAKE_DET_US 410
`define DLDC_WAKE_LOW_US 50
`define DLDC_WAKE_DET_CYC (`DLDC_WAKE_DET_US * `DLDC_CLK_MHZ)
`define DLDC_WAKE_LOW_CYC (`DLDC_WAKE_LOW_US * `DLDC_CLK_MHZ)
`define DLDC_CNT_W 16

`endif

// ### verilog/dldc_wake_det.v
// Wake detector: qualifies a held line short and emits a timed active-low pulse
`timescale 1ns/100ps
`default_nettype none
`include "dldc_consts.vh"

module dldc_wake_det #(
  parameter DET_CYC = `DLDC_WAKE_DET_CYC,
  parameter LOW_CYC = `DLDC_WAKE_LOW_CYC
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // Short indication
  input wire line_short,
  // Wake output
  output reg wake_pulse_n,
  output wire wake_active
);

  localparam ST_IDLE = 3'b001;
  localparam ST_PULSE = 3'b010;
  localparam ST_HOLD = 3'b100;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [`DLDC_CNT_W-1:0] det_cnt_r;
  reg [`DLDC_CNT_W-1:0] low_cnt_r;
  wire det_done;
  wire low_done;

  assign det_done = (det_cnt_r == DET_CYC[`DLDC_CNT_W-1:0] - 16'h0001);
  assign low_done = (low_cnt_r == LOW_CYC[`DLDC_CNT_W-1:0] - 16'h0001);
  assign wake_active = state_r[1];

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (line_short && det_done) state_nxt = ST_PULSE; // R17
      end
      ST_PULSE: begin
        if (low_done) state_nxt = ST_HOLD; // R6
      end
      ST_HOLD: begin
        // One pulse per short; rearm only after release
        if (!line_short) state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      det_cnt_r <= 16'h0000;
      low_cnt_r <= 16'h0000;
      wake_pulse_n <= 1'b1;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_IDLE && line_short && !det_done) begin
        det_cnt_r <= det_cnt_r + 16'h0001; // R17
      end else begin
        det_cnt_r <= 16'h0000;
      end
      if (state_r == ST_PULSE) begin
        low_cnt_r <= low_cnt_r + 16'h0001;
      end else begin
        low_cnt_r <= 16'h0000;
      end
      wake_pulse_n <= ~state_nxt[1]; // R6
    end
  end

endmodule
`default_nettype wire

// ### verif/dldc_line_load.sv
// Sensor and load model on the 24V line
`timescale 1ns/100ps
`default_nettype none
module dldc_line_load (
  // Device drive
  input wire logic drv_out,
  input wire logic drv_oe_n,
  // Load behaviour
  input wire logic short_en,
  input wire logic sensor_level,
  output logic line_level
);
  // A short pulls the line to the rail opposite the drive
  always_comb begin
    if (drv_oe_n)
      line_level = sensor_level;
    else
      line_level = short_en ? ~drv_out : drv_out;
  end
endmodule
`default_nettype wire

// ### verif/dldc_props.sv
// Port checks for the dual line driver control
`timescale 1ns/100ps
`default_nettype none
module dldc_props #(parameter int WAKE_LOW_CYC = 1000) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Inputs
  input wire logic line_driver_enable,
  input wire logic out2_driver_off,
  input wire logic undervolt_detect,
  input wire logic bidir_line_in,
  // Outputs
  input wire logic line_receive_out,
  input wire logic wake_pulse_n,
  input wire logic bidir_line_out,
  input wire logic bidir_line_oe_n,
  input wire logic output_line2_oe_n,
  input wire logic undervoltage_flag_out,
  input wire logic undervoltage_flag_oe_n
);
  logic [15:0] low_cnt_r;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Length of the current wake pulse
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      low_cnt_r <= 16'h0000;
    else
      low_cnt_r <= wake_pulse_n ? 16'h0000 : low_cnt_r + 16'h0001;
  a_out2_off: assert property ($past(rst_b) && $past(out2_driver_off) |-> output_line2_oe_n)
    else $error("out2 drives while off");
  a_line_off: assert property ($past(rst_b) && !$past(line_driver_enable) |-> bidir_line_oe_n)
    else $error("line drives while disabled");
  a_rx_low: assert property (!line_receive_out |-> $past(bidir_line_in))
    else $error("receive low on low line");
  a_rx_high: assert property ($past(rst_b) && !$past(bidir_line_in) |-> line_receive_out)
    else $error("receive not high on low line");
  a_uv_flag: assert property ($past(rst_b) |-> undervoltage_flag_oe_n == $past(undervolt_detect))
    else $error("flag not tracking undervoltage");
  a_uv_open: assert property (undervoltage_flag_out == 1'b0)
    else $error("flag drives high");
  a_wake_src: assert property ($fell(wake_pulse_n) |-> !$past(bidir_line_oe_n) &&
    ($past(bidir_line_in) != $past(bidir_line_out))) else $error("wake without short");
  a_wake_len: assert property ($past(rst_b) && $rose(wake_pulse_n) |-> low_cnt_r == WAKE_LOW_CYC)
    else $error("wake pulse length");
  a_wake_max: assert property (low_cnt_r <= WAKE_LOW_CYC)
    else $error("wake pulse too long");
  c_wake: cover property ($fell(wake_pulse_n));
  c_mask: cover property (line_receive_out && $past(bidir_line_in));
  c_out2: cover property (!output_line2_oe_n);
endmodule
bind dldc_top dldc_props #(.WAKE_LOW_CYC(WAKE_LOW_CYC)) u_props (.sys_clk(sys_clk), .rst_b(rst_b),
  .line_driver_enable(line_driver_enable), .out2_driver_off(out2_driver_off),
  .undervolt_detect(undervolt_detect), .bidir_line_in(bidir_line_in),
  .line_receive_out(line_receive_out), .wake_pulse_n(wake_pulse_n),
  .bidir_line_out(bidir_line_out), .bidir_line_oe_n(bidir_line_oe_n),
  .output_line2_oe_n(output_line2_oe_n), .undervoltage_flag_out(undervoltage_flag_out),
  .undervoltage_flag_oe_n(undervoltage_flag_oe_n));
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the dual line driver control
`timescale 1ns/100ps
`default_nettype none
`include "dldc_consts.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: %h vs %h", $time, a, e); end end
module testbench;
  logic sys_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, li = 0, en = 0, o2in = 0, off = 0;
  logic uvin = 0, sens = 0, short_en = 0, rx, wk, lin, bo, boe, o2, o2oe, uvo, uvoe, dv;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
  logic [11:0] rows [4] = '{12'h428, 12'he83, 12'h154, 12'hb97};
  int num_errors = 0, checks = 0, cyc = 0, n;
  dldc_top #(.WAKE_DET_CYC(20), .WAKE_LOW_CYC(10)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
    .dio_logic_in(li), .line_driver_enable(en), .out2_drive_in(o2in), .out2_driver_off(off),
    .undervolt_detect(uvin), .line_receive_out(rx), .wake_pulse_n(wk), .bidir_line_in(lin),
    .bidir_line_out(bo), .bidir_line_oe_n(boe), .output_line2_out(o2),
    .output_line2_oe_n(o2oe), .undervoltage_flag_out(uvo), .undervoltage_flag_oe_n(uvoe));
  dldc_line_load load (.drv_out(bo), .drv_oe_n(boe), .short_en(short_en),
    .sensor_level(sens), .line_level(lin));
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic test_done;
    if (num_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      test_done;
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = rdata;
  endtask
  task automatic settle;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    // Row: pin inputs, then masked drive, enables, receive and flag release
    for (n = 0; n < 4; n++) begin
      @(posedge sys_clk);
      {li, en, o2in, off, uvin, sens} <= rows[n][11:6];
      settle;
      `CHK({bo & ~boe, boe, o2 & ~o2oe, o2oe, rx, uvoe}, rows[n][5:0])
      `CHK(uvo, 1'b0)
    end
    @(posedge sys_clk);
    {li, en, o2in, off, uvin} <= 5'b01000;
    wr(`DLDC_LINE_CFG_ADDR, 8'h05);
    settle;
    `CHK(rx, 1'b1)
    rd(`DLDC_STATUS_ADDR);
    `CHK(d[`DLDC_ST_LINE_LEVEL], 1'b1)
    rd(8'h10);
    `CHK(d, 8'h00)
    @(posedge sys_clk);
    {li, o2in} <= 2'b11;
    wr(`DLDC_LINE_CFG_ADDR, 8'h79);
    settle;
    `CHK({bo, rx, o2}, 3'b101)
    // Every mode against both levels, drivers left enabled
    for (n = 0; n < 8; n++) begin
      @(posedge sys_clk);
      {li, o2in} <= {2{n[2]}};
      wr(`DLDC_LINE_CFG_ADDR, {6'h00, n[1:0]});
      wr(`DLDC_OUT2_CFG_ADDR, {6'h00, n[1:0]});
      settle;
      dv = n[0] | (n[1] ~^ n[2]);
      `CHK({boe, o2oe}, {2{~dv}})
      if (dv) `CHK({bo, o2}, {2{~n[2]}})
    end
    wr(`DLDC_LINE_CFG_ADDR, 8'h01);
    @(posedge sys_clk);
    short_en <= 1'b1;
    for (n = 0; n < 100 && wk !== 1'b0; n++) @(posedge sys_clk);
    `CHK(n >= 20 && n < 100, 1'b1)
    for (n = 0; n < 50 && wk === 1'b0; n++) @(posedge sys_clk);
    `CHK(n, 10)
    rd(`DLDC_STATUS_ADDR);
    `CHK(d, 8'h09)
    wr(`DLDC_OUT2_CFG_ADDR, 8'hff);
    rd(`DLDC_OUT2_CFG_ADDR);
    `CHK(d, 8'h03)
    // Mid-run reset returns every driver to idle and the line mode to default
    @(posedge sys_clk);
    short_en <= 1'b0;
    rst_b <= 1'b0;
    @(negedge sys_clk);
    `CHK({rx, wk, boe, o2oe, uvoe, rdata}, {5'h1f, 8'h00})
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(`DLDC_LINE_CFG_ADDR);
    `CHK(d, `DLDC_LINE_CFG_RST)
    test_done;
  end
endmodule
`default_nettype wire
